// ===== ivlpc_ctrl.sv
// Summary of operation
// - Vectors sit at fixed table FFE0h-FFFFh
// - All reset causes share top reset vector
// - NMI, oscillator, access faults share vector 14
// - Own enables gate NMI class, not GIE
// - Timer channel 0 has own vector
// - Timer channels 1,2 and overflow share vector
// - Port 1 eight flags share one vector
// - Port 2 flags share lower vector
// - Shared vectors never identify their source
// - Source flags stay inside their peripherals
// - Fetch from peripheral or gap resets device
// - Interrupt wakes device, return restores sleep
// - Run state keeps every clock running
// - Sleep 0 halts CPU, clocks, loop stay
// - Sleep 1 also stops loop control
// - Sleep 2 stops main, loop, oscillator clock
// - Sleep 3 also stops oscillator bias
// - Sleep 4 stops all clocks and crystal
// - Unassigned register bits are not implemented
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module ivlpc_ctrl
    import ivlpc_pkg::*;
#(
    parameter int RST_PULSE = ivlpc_pkg::RST_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // Wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [ivlpc_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // Reset sources
    input  wire logic                        ext_reset_pin_i,
    input  wire logic                        watchdog_expired_i,
    input  wire logic                        flash_key_violation_i,
    // Interrupt flags held in the peripherals
    input  wire logic                        nmi_pin_flag_i,
    input  wire logic                        osc_fault_flag_i,
    input  wire logic                        flash_access_violation_flag_i,
    input  wire logic                        adc_conversion_flag_i,
    input  wire logic                        adc_overflow_flag_i,
    input  wire logic                        watchdog_int_flag_i,
    input  wire logic                        serial_rx_flag_i,
    input  wire logic                        serial_tx_flag_i,
    input  wire logic                        timer_ch0_flag_i,
    input  wire logic [1:0]                  timer_ch12_flags_i,
    input  wire logic                        timer_overflow_flag_i,
    input  wire logic [7:0]                  port1_int_flags_i,
    input  wire logic [7:0]                  port2_int_flags_i,
    input  wire logic                        interval_timer_flag_i,
    // CPU side
    input  wire logic                        fetch_valid_i,
    input  wire logic [15:0]                 fetch_addr_i,
    input  wire logic                        irq_ack_i,
    input  wire logic                        irq_return_i,
    output logic                             irq_o,
    output logic      [15:0]                 vector_addr_o,
    output logic                             sys_reset_o,
    // Clock system enables
    output logic                             cpu_run_o,
    output logic                             main_clock_en_o,
    output logic                             submain_clock_en_o,
    output logic                             aux_clock_en_o,
    output logic                             fll_ctrl_en_o,
    output logic                             osc_clock_en_o,
    output logic                             osc_bias_en_o,
    output logic                             xtal_en_o
);
    import ivlpc_pkg::*;

    // =========================================================
    // State
    logic [6:0]        ctrl;
    logic [15:0]       int_enable;
    logic [RC_W-1:0]   rst_cause;
    ivlpc_mode_e       mode;
    ivlpc_mode_e       saved_mode;
    logic [7:0]        rst_cnt;
    logic              pwr_up_seen;

    // =========================================================
    // Pending sources per priority
    logic [NUM_PRIO-1:0] raw_pend;
    logic [NUM_PRIO-1:0] pend;
    logic [15:0]         ie_eff;
    logic                any_pend;
    logic [PRIO_W-1:0]   top_prio;
    logic                pc_fault;
    logic                rst_event;

    // Shared vectors merge flags by OR and carry no source number
    always_comb begin
        raw_pend                  = '0;
        raw_pend[PRIO_NMI]        = (nmi_pin_flag_i & ctrl[CTRL_NMIE_PIN])
                                  | (osc_fault_flag_i & ctrl[CTRL_NMIE_OSC])
                                  | (flash_access_violation_flag_i
                                     & ctrl[CTRL_NMIE_ACCV]);
        raw_pend[PRIO_ADC]        = adc_conversion_flag_i | adc_overflow_flag_i;
        raw_pend[PRIO_WDOG]       = watchdog_int_flag_i;
        raw_pend[PRIO_SER_RX]     = serial_rx_flag_i;
        raw_pend[PRIO_SER_TX]     = serial_tx_flag_i;
        raw_pend[PRIO_TMR_CH0]    = timer_ch0_flag_i;
        raw_pend[PRIO_TMR_SHARED] = |timer_ch12_flags_i | timer_overflow_flag_i;
        raw_pend[PRIO_PORT1]      = |port1_int_flags_i;
        raw_pend[PRIO_PORT2]      = |port2_int_flags_i;
        raw_pend[PRIO_INTERVAL]   = interval_timer_flag_i;
    end

    // Global enable gates only maskable vectors
    always_comb begin
        ie_eff           = int_enable & {16{ctrl[CTRL_GIE]}};
        ie_eff[PRIO_NMI] = 1'b1;
        pend             = raw_pend & ie_eff;
    end

    always_comb begin
        top_prio = '0;
        any_pend = 1'b0;
        for (int i = 0; i < NUM_PRIO; i++) begin
            if (pend[i]) begin
                top_prio = PRIO_W'(i);
                any_pend = 1'b1;
            end
        end
    end

    // =========================================================
    // Reset generation
    always_comb begin
        pc_fault = fetch_valid_i
                 & ((fetch_addr_i <= PERIPH_TOP)
                    | ((fetch_addr_i >= GAP_LOW) & (fetch_addr_i <= GAP_HIGH)));
        rst_event = ext_reset_pin_i | watchdog_expired_i
                  | flash_key_violation_i | pc_fault;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwr_up_seen <= 1'b0;
        end else begin
            pwr_up_seen <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cnt     <= 8'(RST_PULSE);
            sys_reset_o <= 1'b1;
        end else if (rst_event) begin
            rst_cnt     <= 8'(RST_PULSE);
            sys_reset_o <= 1'b1;
        end else if (rst_cnt != 8'h00) begin
            rst_cnt     <= rst_cnt - 8'h01;
            sys_reset_o <= 1'b1;
        end else begin
            sys_reset_o <= 1'b0;
        end
    end

    // =========================================================
    // Wishbone slave
    logic        wb_req;
    logic        wb_wr;
    logic [31:0] rd_data;
    logic [31:0] wmask;

    always_comb begin
        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        wb_wr  = wb_req & wb_we_i;
        wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    end

    // Unassigned bits are not stored and read as zero
    always_comb begin
        rd_data = '0;
        unique case (wb_adr_i)
            REG_CTRL:       rd_data[6:0]      = ctrl;
            REG_INT_ENABLE: rd_data[15:0]     = int_enable;
            REG_STATUS:     rd_data           = {10'h000, mode, saved_mode,
                                                 5'h00, any_pend, top_prio};
            REG_RST_CAUSE:  rd_data[RC_W-1:0] = rst_cause;
            default:        rd_data           = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : '0;
        end
    end

    // Control register; GIE dropped by hardware on vector take
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_reset_o) begin
            ctrl <= '0;
        end else begin
            if (wb_wr && wb_adr_i == REG_CTRL) begin
                ctrl <= (ctrl & ~wmask[6:0]) | (wb_dat_i[6:0] & wmask[6:0]);
                ctrl[CTRL_SLEEP_HI:CTRL_SLEEP_LO] <= '0;
            end
            if (irq_ack_i) begin
                ctrl[CTRL_GIE] <= 1'b0;
            end
            // Return wins when it meets an ack in one cycle
            if (irq_return_i) begin
                ctrl[CTRL_GIE] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || sys_reset_o) begin
            int_enable <= '0;
        end else if (wb_wr && wb_adr_i == REG_INT_ENABLE) begin
            int_enable <= ((int_enable & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]))
                        & IE_IMPL_MASK;
        end
    end

    // Sticky causes, write one to clear, new cause wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_cause <= '0;
        end else begin
            if (wb_wr && wb_adr_i == REG_RST_CAUSE) begin
                rst_cause <= rst_cause & ~(wb_dat_i[RC_W-1:0] & wmask[RC_W-1:0]);
            end
            if (!pwr_up_seen) begin
                rst_cause[RC_POWER_UP] <= 1'b1;
            end
            if (ext_reset_pin_i) begin
                rst_cause[RC_PIN] <= 1'b1;
            end
            if (watchdog_expired_i) begin
                rst_cause[RC_WATCHDOG] <= 1'b1;
            end
            if (flash_key_violation_i) begin
                rst_cause[RC_KEY] <= 1'b1;
            end
            if (pc_fault) begin
                rst_cause[RC_PC_RANGE] <= 1'b1;
            end
        end
    end

    // =========================================================
    // Operating mode
    logic [2:0]  sleep_req;
    ivlpc_mode_e req_mode;

    always_comb begin
        sleep_req = wb_dat_i[CTRL_SLEEP_HI:CTRL_SLEEP_LO];
        unique case (sleep_req)
            3'h1:    req_mode = MODE_SLEEP_0;
            3'h2:    req_mode = MODE_SLEEP_1;
            3'h3:    req_mode = MODE_SLEEP_2;
            3'h4:    req_mode = MODE_SLEEP_3;
            3'h5:    req_mode = MODE_SLEEP_4;
            default: req_mode = MODE_RUN_STATE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || sys_reset_o) begin
            mode       <= MODE_RUN_STATE;
            saved_mode <= MODE_RUN_STATE;
        end else if (mode != MODE_RUN_STATE) begin
            if (any_pend) begin
                saved_mode <= mode;
                mode       <= MODE_RUN_STATE;
            end
        end else if (irq_return_i) begin
            mode       <= saved_mode;
            saved_mode <= MODE_RUN_STATE;
        end else if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
            mode <= req_mode;
        end
    end

    // Mode groups that share clock behaviour
    logic run_now;
    logic loop_on;
    logic fast_on;
    logic bias_on;
    logic aux_on;

    always_comb begin
        run_now = (mode == MODE_RUN_STATE);
        loop_on = run_now | (mode == MODE_SLEEP_0);
        fast_on = loop_on | (mode == MODE_SLEEP_1);
        bias_on = ~((mode == MODE_SLEEP_3) | (mode == MODE_SLEEP_4));
        aux_on  = (mode != MODE_SLEEP_4);
    end

    // Clock enables per mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_run_o          <= 1'b1;
            main_clock_en_o    <= 1'b1;
            submain_clock_en_o <= 1'b1;
            aux_clock_en_o     <= 1'b1;
            fll_ctrl_en_o      <= 1'b1;
            osc_clock_en_o     <= 1'b1;
            osc_bias_en_o      <= 1'b1;
            xtal_en_o          <= 1'b1;
        end else begin
            cpu_run_o          <= run_now;
            main_clock_en_o    <= fast_on;
            submain_clock_en_o <= fast_on;
            fll_ctrl_en_o      <= loop_on;
            osc_clock_en_o     <= fast_on;
            osc_bias_en_o      <= bias_on;
            aux_clock_en_o     <= aux_on;
            xtal_en_o          <= aux_on;
        end
    end

    // =========================================================
    // Vector to CPU
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_reset_o) begin
            irq_o         <= 1'b0;
            vector_addr_o <= VEC_RESET;
        end else begin
            irq_o         <= any_pend & ~irq_ack_i;
            vector_addr_o <= VEC_TABLE_BASE + {11'h000, top_prio, 1'b0};
        end
    end

endmodule

`default_nettype wire

// ===== ivlpc_pkg.sv
package ivlpc_pkg;

    // =========================================================
    // Vector table
    localparam logic [15:0] VEC_TABLE_BASE  = 16'hffe0;
    localparam logic [15:0] VEC_TABLE_TOP   = 16'hffff;
    localparam logic [15:0] VEC_RESET       = 16'hfffe;
    localparam int          PRIO_W          = 4;
    localparam int          NUM_PRIO        = 16;
    localparam logic [3:0]  PRIO_RESET      = 4'hf;
    localparam logic [3:0]  PRIO_NMI        = 4'he;
    localparam logic [3:0]  PRIO_ADC        = 4'hc;
    localparam logic [3:0]  PRIO_WDOG       = 4'ha;
    localparam logic [3:0]  PRIO_SER_RX     = 4'h9;
    localparam logic [3:0]  PRIO_SER_TX     = 4'h8;
    localparam logic [3:0]  PRIO_TMR_CH0    = 4'h6;
    localparam logic [3:0]  PRIO_TMR_SHARED = 4'h5;
    localparam logic [3:0]  PRIO_PORT1      = 4'h4;
    localparam logic [3:0]  PRIO_PORT2      = 4'h1;
    localparam logic [3:0]  PRIO_INTERVAL   = 4'h0;
    // Priorities with a source except NMI (14); other enable bits are not built
    localparam logic [15:0] IE_IMPL_MASK    = 16'h1773;

    // =========================================================
    // Fetch ranges that force a reset
    localparam logic [15:0] PERIPH_TOP      = 16'h01ff;
    localparam logic [15:0] GAP_LOW         = 16'h0600;
    localparam logic [15:0] GAP_HIGH        = 16'h0bff;

    // =========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  REG_CTRL        = 8'h00;
    localparam logic [7:0]  REG_INT_ENABLE  = 8'h04;
    localparam logic [7:0]  REG_STATUS      = 8'h08;
    localparam logic [7:0]  REG_RST_CAUSE   = 8'h0c;
    localparam int          ADDR_W          = 8;
    // CTRL fields
    localparam int          CTRL_GIE        = 0;
    localparam int          CTRL_SLEEP_LO   = 1;
    localparam int          CTRL_SLEEP_HI   = 3;
    localparam int          CTRL_NMIE_PIN   = 4;
    localparam int          CTRL_NMIE_OSC   = 5;
    localparam int          CTRL_NMIE_ACCV  = 6;
    // Reset cause bits
    localparam int          RC_POWER_UP     = 0;
    localparam int          RC_PIN          = 1;
    localparam int          RC_WATCHDOG     = 2;
    localparam int          RC_KEY          = 3;
    localparam int          RC_PC_RANGE     = 4;
    localparam int          RC_W            = 5;

    // =========================================================
    // Timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          RST_PULSE_NS    = 100;
    localparam int          RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // =========================================================
    // Operating modes, one-hot
    typedef enum logic [5:0] {
        MODE_RUN_STATE = 6'h01,
        MODE_SLEEP_0   = 6'h02,
        MODE_SLEEP_1   = 6'h04,
        MODE_SLEEP_2   = 6'h08,
        MODE_SLEEP_3   = 6'h10,
        MODE_SLEEP_4   = 6'h20
    } ivlpc_mode_e;

endpackage

// ===== ivlpc_chk.sv
`timescale 1ns/10ps
`default_nettype none

module ivlpc_chk (
    // Clock and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    // Reset sources and CPU side
    input wire logic        ext_reset_pin_i,
    input wire logic        watchdog_expired_i,
    input wire logic        flash_key_violation_i,
    input wire logic        fetch_valid_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic        irq_ack_i,
    input wire logic        irq_o,
    input wire logic [15:0] vector_addr_o,
    input wire logic        sys_reset_o,
    // Clock enables
    input wire logic        cpu_run_o,
    input wire logic        main_clock_en_o,
    input wire logic        submain_clock_en_o,
    input wire logic        aux_clock_en_o,
    input wire logic        fll_ctrl_en_o,
    input wire logic        osc_clock_en_o,
    input wire logic        osc_bias_en_o,
    input wire logic        xtal_en_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // =========================================================
    // Bus and reset
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    src_rst_a: assert property (
        (ext_reset_pin_i || watchdog_expired_i || flash_key_violation_i) |=> sys_reset_o)
        else $error("reset source did not reset the device");
    pc_rst_a: assert property (
        fetch_valid_i && (fetch_addr_i <= 16'h01ff || (fetch_addr_i >= 16'h0600
        && fetch_addr_i <= 16'h0bff)) |=> sys_reset_o)
        else $error("illegal fetch did not reset the device");
    rst_vec_a: assert property (
        sys_reset_o && $past(sys_reset_o) |-> vector_addr_o == 16'hfffe)
        else $error("vector not the reset vector during reset");

    // =========================================================
    // Vectors and clock modes
    vec_tab_a: assert property (
        irq_o |-> vector_addr_o[15:5] == 11'h7ff && !vector_addr_o[0])
        else $error("vector outside the table");
    ack_drop_a: assert property (irq_ack_i |=> !irq_o)
        else $error("request stayed up after the vector was taken");
    run_clk_a: assert property (
        cpu_run_o |-> main_clock_en_o && submain_clock_en_o && aux_clock_en_o
        && fll_ctrl_en_o && osc_clock_en_o && osc_bias_en_o && xtal_en_o)
        else $error("clock stopped while running");
    lp_zero_a: assert property (
        !cpu_run_o && fll_ctrl_en_o |-> main_clock_en_o && submain_clock_en_o && aux_clock_en_o)
        else $error("light sleep stopped a clock");
    lp_main_a: assert property (
        !main_clock_en_o |-> !fll_ctrl_en_o && !osc_clock_en_o && !cpu_run_o)
        else $error("deep sleep left a fast clock on");
    lp_aux_a: assert property (
        !aux_clock_en_o |-> !xtal_en_o && !osc_bias_en_o && !main_clock_en_o)
        else $error("full stop left the oscillator on");

    wake_c: cover property ($rose(cpu_run_o));
    stop_c: cover property (!xtal_en_o);
    fetch_c: cover property (fetch_valid_i ##1 sys_reset_o);
endmodule

bind ivlpc_ctrl ivlpc_chk u_chk (.*);

`default_nettype wire

// ===== ivlpc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module ivlpc_cpu_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Core side
    input  wire logic       irq_i,
    input  wire logic       auto_i,
    input  wire logic [2:0] dly_i,
    output logic            ack_o,
    output logic            ret_o
);
    logic       busy = 1'b0;
    logic [2:0] cnt = 3'h0;

    // Takes the vector dly_i cycles after a request, returns five cycles later
    always_ff @(posedge clk_i) begin
        ack_o <= 1'b0;
        ret_o <= 1'b0;
        cnt   <= cnt + 3'h1;
        if (rst_i || (!busy && !(auto_i && irq_i))) begin
            busy <= 1'b0;
            cnt  <= 3'h0;
        end else if (!busy && cnt >= dly_i) begin
            ack_o <= 1'b1;
            busy  <= 1'b1;
            cnt   <= 3'h0;
        end else if (busy && cnt == 3'h4) begin
            ret_o <= 1'b1;
            busy  <= 1'b0;
            cnt   <= 3'h0;
        end
    end
endmodule

`default_nettype wire

// ===== irq_vector_lowpower_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module irq_vector_lowpower_ctrl_tb;
    import ivlpc_pkg::*;
    localparam logic [3:0]  PR [11] = '{4'hc, 4'hc, 4'ha, 4'h9, 4'h8, 4'h6, 4'h5, 4'h5,
                                        4'h4, 4'h1, 4'h0};
    localparam logic [7:0]  CK [6] = '{8'hff, 8'h7f, 8'h77, 8'h13, 8'h11, 8'h00};
    localparam logic [15:0] FA [6] = '{16'h0, 16'h1ff, 16'h200, 16'h600, 16'hbff, 16'hc00};
    localparam logic        FR [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, fv = 1'b0, auto = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0, e;
    logic [2:0]  rst_src = 3'h0, nmi = 3'h0, dly = 3'h0, pos = 3'h0;
    logic [10:0] src = 11'h0, m;
    logic [15:0] fa = 16'h0;
    wire  [7:0]  ck;
    wire  [15:0] vec;
    wire  [31:0] rdat;
    wire         irq, srst, ackw, ack, ret;
    int          fail_count = 0, checks = 0, seed = 25407;
    logic [31:0] q[$];

    ivlpc_ctrl #(.RST_PULSE(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ackw), .ext_reset_pin_i(rst_src[0]),
        .watchdog_expired_i(rst_src[1]), .flash_key_violation_i(rst_src[2]),
        .nmi_pin_flag_i(nmi[0]), .osc_fault_flag_i(nmi[1]),
        .flash_access_violation_flag_i(nmi[2]), .adc_conversion_flag_i(src[0]),
        .adc_overflow_flag_i(src[1]), .watchdog_int_flag_i(src[2]), .serial_rx_flag_i(src[3]),
        .serial_tx_flag_i(src[4]), .timer_ch0_flag_i(src[5]),
        .timer_ch12_flags_i(src[6] ? 2'h1 << pos[0] : 2'h0), .timer_overflow_flag_i(src[7]),
        .port1_int_flags_i(src[8] ? 8'h1 << pos : 8'h0),
        .port2_int_flags_i(src[9] ? 8'h1 << pos : 8'h0), .interval_timer_flag_i(src[10]),
        .fetch_valid_i(fv), .fetch_addr_i(fa), .irq_ack_i(ack), .irq_return_i(ret),
        .irq_o(irq), .vector_addr_o(vec), .sys_reset_o(srst), .cpu_run_o(ck[7]),
        .main_clock_en_o(ck[6]), .submain_clock_en_o(ck[5]), .aux_clock_en_o(ck[4]),
        .fll_ctrl_en_o(ck[3]), .osc_clock_en_o(ck[2]), .osc_bias_en_o(ck[1]), .xtal_en_o(ck[0]));
    ivlpc_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .auto_i(auto),
        .dly_i(dly), .ack_o(ack), .ret_o(ret));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // =========================================================
    // Checking and waiting
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    function automatic logic hit(input int k);
        case (k)
            0: return ackw;
            1: return ack;
            2: return ret;
            default: return !srst;
        endcase
    endfunction
    task automatic wt(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hit(k) !== 1'b1 && n < 300);
        if (n >= 300) begin
            fail_count++;
            print_verdict();
        end
    endtask
    always @(posedge clk_i) begin
        if (ackw === 1'b1 && !we) begin
            if (q.size() == 0)
                cmp("unexpected read", 32'h1, 32'h0);
            else
                cmp("read data", q.pop_front(), rdat);
        end
    end
    task automatic chk_irq(input logic i, input logic [15:0] v);
        @(negedge clk_i);
        cmp("irq", {31'h0, i}, {31'h0, irq});
        if (i)
            cmp("vector", {16'h0, v}, {16'h0, vec});
    endtask
    task automatic chk_clk(input logic [7:0] x);
        @(negedge clk_i);
        cmp("clock enables", {24'h0, x}, {24'h0, ck});
    endtask

    // =========================================================
    // Stimulus
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clk_i);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        wt(0);
        cyc  <= 1'b0;
        we   <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(x);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    task automatic put(input logic [10:0] s, input logic [2:0] n);
        @(posedge clk_i);
        src <= s;
        nmi <= n;
        pos <= 3'($random(seed));
        repeat (3) @(posedge clk_i);
    endtask
    task automatic poke(input logic [2:0] r, input logic [15:0] a, input logic f,
                        input logic [31:0] x);
        @(posedge clk_i);
        rst_src <= r;
        fv      <= f;
        fa      <= a;
        @(posedge clk_i);
        rst_src <= 3'h0;
        fv      <= 1'b0;
        repeat (2) @(posedge clk_i);
        wt(3);
        rd(REG_RST_CAUSE, x);
        bus(1'b1, REG_RST_CAUSE, 32'h1f, 4'hf);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wt(3);
        rd(REG_RST_CAUSE, 32'h1);
        bus(1'b1, REG_RST_CAUSE, 32'h1f, 4'hf);
        bus(1'b1, REG_INT_ENABLE, 32'hffffffff, 4'h1);
        rd(REG_INT_ENABLE, 32'h73);
        bus(1'b1, REG_INT_ENABLE, 32'hffffbfff, 4'hf);
        bus(1'b1, REG_CTRL, 32'h1, 4'hf);
        rd(REG_INT_ENABLE, 32'h1773);
        rd(8'h10, 32'h0);
        for (int i = 0; i < 11; i++) begin
            put(11'h1 << i, 3'h0);
            chk_irq(1'b1, 16'hffe0 + {11'h0, PR[i], 1'b0});
            rd(REG_STATUS, 32'h10410 | 32'(PR[i]));
        end
        for (int i = 0; i < 8; i++) begin
            m = 11'($random(seed) & $random(seed) & $random(seed)) | (11'h400 >> i);
            e = 4'h0;
            for (int j = 0; j < 11; j++)
                if (m[j] && PR[j] > e)
                    e = PR[j];
            put(m, 3'h0);
            chk_irq(1'b1, 16'hffe0 + {11'h0, e, 1'b0});
        end
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, REG_CTRL, 32'h10 << k, 4'hf);
            put(11'h100, 3'h7);
            chk_irq(1'b1, 16'hfffc);
            bus(1'b1, REG_CTRL, 32'h70 & ~(32'h10 << k), 4'hf);
            put(11'h100, 3'h1 << k);
            chk_irq(1'b0, 16'h0);
        end
        put(11'h0, 3'h0);
        for (int c = 1; c < 6; c++) begin
            dly <= 3'($random(seed));
            bus(1'b1, REG_CTRL, 32'(c * 2 + 1), 4'hf);
            auto <= 1'b1;
            repeat (2) @(posedge clk_i);
            chk_clk(CK[c]);
            @(posedge clk_i);
            src <= 11'h100;
            wt(1);
            src  <= 11'h0;
            auto <= 1'b0;
            chk_clk(8'hff);
            wt(2);
            repeat (2) @(posedge clk_i);
            chk_clk(CK[c]);
            put(11'h100, 3'h0);
            chk_clk(8'hff);
            put(11'h0, 3'h0);
        end
        for (int i = 0; i < 6; i++)
            poke(3'h0, FA[i], 1'b1, {27'h0, FR[i], 4'h0});
        for (int i = 0; i < 3; i++)
            poke(3'h1 << i, 16'h0, 1'b0, 32'h2 << i);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wt(3);
        rd(REG_RST_CAUSE, 32'h1);
        print_verdict();
    end
endmodule

`default_nettype wire
